// file: design/capture_timer_control_irq.sv
// Control, interrupt and sleep logic of a 16-bit capture/compare timer.
// Assumes a byte register port on ref_clk, companion inputs already synchronous.
`timescale 1ns/10ps
module capture_timer_control_irq
    import capture_timer_pkg::*;
(
    // Clock and reset
    input  wire logic       ref_clk,
    input  wire logic       rst,
    // Register port
    input  wire logic [3:0] regAddr,
    input  wire logic [7:0] regWdata,
    input  wire logic       regWr,
    input  wire logic       regRd,
    output logic      [7:0] regRdata,
    // Sleep state
    input  wire logic       sleepStandby,
    input  wire logic       sleepPowerDown,
    // Companion timer
    input  wire logic       companionTick,
    input  wire logic       companionRestart,
    // Event input (asynchronous pin domain)
    input  wire logic       eventIn,
    // Port pin
    input  wire logic       portOutValue,
    output logic            pinOut,
    // Interrupt and event out
    output logic            irq,
    output logic            snapshotEvent
);

    ////////////////////////////////////////////////////////////////////////////
    // Registers
    logic [7:0]  controlA_reg;       // Enable, clock select, sync, standby
    logic [7:0]  controlB_reg;       // Mode, output options
    logic [7:0]  eventControl_reg;   // Event enable and edge
    logic [7:0]  irqEnable_reg;      // Snapshot interrupt enable
    logic [7:0]  debugControl_reg;   // Kept for software only
    logic [7:0]  byteBuffer_reg;     // High byte staging
    logic [15:0] counter_reg;        // Counter value
    logic [15:0] compare_reg;        // Top or captured value
    logic [7:0]  regRdata_reg;       // Read data, one cycle later
    logic        halfPhase_reg;      // Half-rate toggle
    logic        running_reg;        // Counter active
    logic        waveform_reg;       // Waveform level
    logic        evSync1_reg;        // Event synchroniser stage 1
    logic        evSync2_reg;        // Event synchroniser stage 2
    logic        evPrev_reg;         // Previous synced event level
    logic        asyncHit_reg;       // Event seen, output raised early

    logic        flag;
    logic        tick;
    logic        active;
    logic        topHit;
    logic        evRise;
    logic        evFall;
    logic        evActive;
    logic        startEvent;
    logic        captureEvent;
    logic        flagSet;
    logic        flagClear;
    logic        outLevel;
    logic [2:0]  mode;
    logic [1:0]  clock_source_select;

    assign mode   = controlB_reg[2:0];
    assign clock_source_select = controlA_reg[BIT_CLOCK_SOURCE_SELECT_LO +: 2];

    ////////////////////////////////////////////////////////////////////////////
    // Sleep gating
    // Companion clock ignores run-in-standby; power-down always wins
    always_comb begin
        active = controlA_reg[BIT_ENABLE];
        if (sleepPowerDown) begin
            active = 1'b0;
        end else if (sleepStandby) begin
            if (clock_source_select == COMPANION_TIMER_CLOCK) begin
                active = 1'b0;
            end else if (!controlA_reg[BIT_RUN_STANDBY]) begin
                active = 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Clock source
    // Half rate toggles every cycle while active
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            halfPhase_reg <= 1'b0;
        end else if (active) begin
            halfPhase_reg <= ~halfPhase_reg;
        end
    end

    // Reserved select code stops counting
    always_comb begin
        unique case (clock_source_select)
            FULL_RATE_CLOCK:       tick = active;
            HALF_RATE_CLOCK:       tick = active & halfPhase_reg;
            COMPANION_TIMER_CLOCK: tick = active & companionTick;
            default:               tick = 1'b0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Event input synchroniser and edges
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            evSync1_reg <= 1'b0;
            evSync2_reg <= 1'b0;
            evPrev_reg  <= 1'b0;
        end else begin
            evSync1_reg <= eventIn;
            evSync2_reg <= evSync1_reg;
            evPrev_reg  <= evSync2_reg;
        end
    end

    assign evRise   = evSync2_reg & ~evPrev_reg;
    assign evFall   = ~evSync2_reg & evPrev_reg;
    // Edge polarity picked by the edge bit
    assign evActive = eventControl_reg[BIT_EVENT_EN] &
                      (eventControl_reg[BIT_EVENT_EDGE] ? evFall : evRise);
    assign startEvent   = (mode == ONE_SHOT_MODE) && eventControl_reg[BIT_EVENT_EN] &&
                          (evRise || (eventControl_reg[BIT_EVENT_EDGE] && evFall));
    assign captureEvent = is_capture_mode(mode) && evActive && active;

    ////////////////////////////////////////////////////////////////////////////
    // Counter
    assign topHit = tick && (counter_reg == compare_reg) &&
                    ((mode == PERIODIC_MODE) || (mode == TIMEOUT_MODE) || (mode == ONE_SHOT_MODE));

    // One-shot runs from event to top; other modes run while enabled
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            running_reg <= 1'b0;
        end else if (!controlA_reg[BIT_ENABLE]) begin
            running_reg <= 1'b0;
        end else if (mode != ONE_SHOT_MODE) begin
            running_reg <= 1'b1;
        end else if (startEvent) begin
            running_reg <= 1'b1;
        end else if (topHit) begin
            running_reg <= 1'b0;
        end
    end

    // Counter update, including software byte writes
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            counter_reg <= RESET_WORD;
        end else if (regWr && regAddr == OFF_COUNTER_HI) begin
            counter_reg <= {regWdata, byteBuffer_reg};
        end else if (controlA_reg[BIT_SYNC_COMP] && companionRestart && active) begin
            counter_reg <= COUNT_BOTTOM;
        end else if (captureEvent && mode != CAPTURE_MODE) begin
            counter_reg <= COUNT_BOTTOM;
        end else if (topHit) begin
            counter_reg <= COUNT_BOTTOM;
        end else if (tick && running_reg) begin
            counter_reg <= counter_reg + COUNT_STEP;
        end
    end

    // Compare register: software top or captured count
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            compare_reg <= RESET_WORD;
        end else if (regWr && regAddr == OFF_COMPARE_HI) begin
            compare_reg <= {regWdata, byteBuffer_reg};
        end else if (captureEvent) begin
            compare_reg <= counter_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Waveform output
    // Async start raises output at the event, before the synchroniser
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            asyncHit_reg <= 1'b0;
        end else if (running_reg || !controlA_reg[BIT_ENABLE]) begin
            asyncHit_reg <= 1'b0;
        end else if (eventIn && eventControl_reg[BIT_EVENT_EN]) begin
            asyncHit_reg <= 1'b1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            waveform_reg <= 1'b0;
        end else if (!controlA_reg[BIT_ENABLE] && mode != ONE_SHOT_MODE && mode != EIGHT_BIT_PULSE_MODE) begin
            waveform_reg <= controlB_reg[BIT_INIT_LEVEL];
        end else if (mode == ONE_SHOT_MODE) begin
            waveform_reg <= running_reg;
        end else if (mode == EIGHT_BIT_PULSE_MODE) begin
            waveform_reg <= (counter_reg[7:0] < compare_reg[15:8]);
        end
    end

    // Async path lets the raw event drive the pin combinationally
    always_comb begin
        outLevel = waveform_reg;
        if (mode == ONE_SHOT_MODE && controlB_reg[BIT_ASYNC_START] &&
            controlA_reg[BIT_ENABLE] && eventControl_reg[BIT_EVENT_EN] &&
            (eventIn || asyncHit_reg)) begin
            outLevel = 1'b1;
        end
    end

    // Pin direction is the port's business; we only pick the value
    assign pinOut = controlB_reg[BIT_WAVE_EN] ? outLevel : portOutValue;

    ////////////////////////////////////////////////////////////////////////////
    // Interrupt
    assign flagSet   = topHit | captureEvent;
    assign flagClear = (regWr && regAddr == OFF_IRQ_FLAGS && regWdata[BIT_SNAPSHOT]) ||
                       (regRd && regAddr == OFF_COMPARE_LO && is_capture_mode(mode));

    snapshot_irq uIrq (
        .ref_clk    (ref_clk),
        .rst        (rst),
        .setEvent   (flagSet),
        .clearEvent (flagClear),
        .enable     (irqEnable_reg[BIT_SNAPSHOT]),
        .flag       (flag),
        .irq        (irq)
    );

    assign snapshotEvent = flagSet;

    ////////////////////////////////////////////////////////////////////////////
    // Register writes
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            controlA_reg     <= RESET_BYTE;
            controlB_reg     <= RESET_BYTE;
            eventControl_reg <= RESET_BYTE;
            irqEnable_reg    <= RESET_BYTE;
            debugControl_reg <= RESET_BYTE;
        end else if (regWr) begin
            unique case (regAddr)
                OFF_CONTROL_A:  controlA_reg     <= regWdata & MASK_CONTROL_A;
                OFF_CONTROL_B:  controlB_reg     <= regWdata & MASK_CONTROL_B;
                OFF_EVENT_CTRL: eventControl_reg <= regWdata & MASK_EVENT_CTRL;
                OFF_IRQ_ENABLE: irqEnable_reg    <= regWdata & MASK_ONE_BIT;
                OFF_DEBUG_CTRL: debugControl_reg <= regWdata & MASK_ONE_BIT;
                default: ;
            endcase
        end
    end

    // Byte buffer: low write stages, low read latches the high half
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            byteBuffer_reg <= RESET_BYTE;
        end else if (regWr && (regAddr == OFF_COUNTER_LO || regAddr == OFF_COMPARE_LO ||
                               regAddr == OFF_BYTE_BUFFER)) begin
            byteBuffer_reg <= regWdata;
        end else if (regRd && regAddr == OFF_COUNTER_LO) begin
            byteBuffer_reg <= counter_reg[15:8];
        end else if (regRd && regAddr == OFF_COMPARE_LO) begin
            byteBuffer_reg <= compare_reg[15:8];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Register reads; unmapped offsets read zero
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            regRdata_reg <= RESET_BYTE;
        end else if (regRd) begin
            unique case (regAddr)
                OFF_CONTROL_A:   regRdata_reg <= controlA_reg;
                OFF_CONTROL_B:   regRdata_reg <= controlB_reg;
                OFF_EVENT_CTRL:  regRdata_reg <= eventControl_reg;
                OFF_IRQ_ENABLE:  regRdata_reg <= irqEnable_reg;
                OFF_IRQ_FLAGS:   regRdata_reg <= {7'h00, flag};
                OFF_RUN_STATE:   regRdata_reg <= {7'h00, running_reg};
                OFF_DEBUG_CTRL:  regRdata_reg <= debugControl_reg;
                OFF_BYTE_BUFFER: regRdata_reg <= byteBuffer_reg;
                OFF_COUNTER_LO:  regRdata_reg <= counter_reg[7:0];
                OFF_COUNTER_HI:  regRdata_reg <= byteBuffer_reg;
                OFF_COMPARE_LO:  regRdata_reg <= compare_reg[7:0];
                OFF_COMPARE_HI:  regRdata_reg <= byteBuffer_reg;
                default:         regRdata_reg <= RESET_BYTE;
            endcase
        end else begin
            regRdata_reg <= RESET_BYTE;
        end
    end

    assign regRdata = regRdata_reg;

endmodule : capture_timer_control_irq

// file: design/snapshot_irq.sv
// Snapshot interrupt flag with enable and level request.
// Assumes set and clear inputs come from logic on ref_clk.
`timescale 1ns/10ps
module snapshot_irq
    import capture_timer_pkg::*;
(
    // Clock and reset
    input  wire logic ref_clk,
    input  wire logic rst,
    // Events
    input  wire logic setEvent,
    input  wire logic clearEvent,
    input  wire logic enable,
    // Results
    output logic      flag,
    output logic      irq
);
    logic flag_reg;    // Sticky snapshot flag

    // Flag set regardless of enable; set beats clear
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            flag_reg <= 1'b0;
        end else if (setEvent) begin
            flag_reg <= 1'b1;
        end else if (clearEvent) begin
            flag_reg <= 1'b0;
        end
    end

    assign flag = flag_reg;
    // Request held while flag and enable both set
    assign irq  = flag_reg & enable;
endmodule : snapshot_irq

// file: dv/capture_timer_assertions.sv
// Port checker for the timer control block.
// Assumes binding into capture_timer_control_irq, single ref_clk domain.
`timescale 1ns/10ps
module capture_timer_assertions
    import capture_timer_pkg::*;
(
    // Clock and reset
    input wire logic       ref_clk,
    input wire logic       rst,
    // Register port
    input wire logic [3:0] regAddr,
    input wire logic [7:0] regWdata,
    input wire logic       regWr,
    input wire logic       regRd,
    input wire logic [7:0] regRdata,
    // Sleep, pin and interrupt
    input wire logic       sleepStandby,
    input wire logic       sleepPowerDown,
    input wire logic       portOutValue,
    input wire logic       pinOut,
    input wire logic       irq,
    input wire logic       snapshotEvent
);
    logic [7:0] ctrlShadow; // Control A as software wrote it
    logic       waveShadow; // Waveform enable copy
    logic       enShadow;   // Interrupt enable copy

    ////////////////////////////////////////////////////////////////////////
    // Shadows track writes only; masks keep them equal to the real fields
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            ctrlShadow <= 8'h00;
            waveShadow <= 1'b0;
            enShadow   <= 1'b0;
        end else if (regWr) begin
            if (regAddr == OFF_CONTROL_A) begin
                ctrlShadow <= regWdata & MASK_CONTROL_A;
            end
            if (regAddr == OFF_CONTROL_B) begin
                waveShadow <= regWdata[BIT_WAVE_EN];
            end
            if (regAddr == OFF_IRQ_ENABLE) begin
                enShadow <= regWdata[0];
            end
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    // Three cycles give a registered event pulse time to drain
    sequence pdHeld;
        sleepPowerDown [*3];
    endsequence
    sequence stbyHeld;
        (sleepStandby && (!ctrlShadow[BIT_RUN_STANDBY] || ctrlShadow[2:1] == 2'h3)) [*3];
    endsequence
    sequence offHeld;
        !ctrlShadow[BIT_ENABLE] [*3];
    endsequence

    a_irq_gated: assert property (irq |-> enShadow)
        else $error("irq high while its source is disabled");
    a_irq_follows: assert property (snapshotEvent && enShadow && !(regWr && regAddr == OFF_IRQ_ENABLE)
        |-> ##[0:1] irq)
        else $error("enabled snapshot did not raise irq");
    a_irq_holds: assert property (irq && !(regWr && regAddr == OFF_IRQ_FLAGS && regWdata[0])
        && !(regRd && regAddr == OFF_COMPARE_LO) && !(regWr && regAddr == OFF_IRQ_ENABLE) |=> irq)
        else $error("irq dropped without a clear");
    a_enable_read: assert property (regRd && regAddr == OFF_IRQ_ENABLE |=> regRdata == {7'h00, enShadow})
        else $error("interrupt enable read back wrong");
    a_ctrl_read: assert property (regRd && regAddr == OFF_CONTROL_A |=> regRdata == ctrlShadow)
        else $error("control A read back wrong");
    a_pin_port: assert property (!waveShadow |-> pinOut == portOutValue)
        else $error("waveform reached pin while disabled");
    a_pd_quiet: assert property (pdHeld |-> !snapshotEvent)
        else $error("snapshot during power-down");
    a_stby_quiet: assert property (stbyHeld |-> !snapshotEvent)
        else $error("snapshot during halting standby");
    a_off_quiet: assert property (offHeld |-> !snapshotEvent)
        else $error("snapshot while timer disabled");
endmodule : capture_timer_assertions

bind capture_timer_control_irq capture_timer_assertions u_checks (
    .ref_clk(ref_clk), .rst(rst), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
    .regRdata(regRdata), .sleepStandby(sleepStandby), .sleepPowerDown(sleepPowerDown),
    .portOutValue(portOutValue), .pinOut(pinOut), .irq(irq), .snapshotEvent(snapshotEvent));

// file: dv/companion_model.sv
// Far-side model: companion timer ticks and restarts, event channel.
// Assumes one ref_clk domain; ticks and restarts are synchronous single pulses, eventIn follows eventReq.
`timescale 1ns/10ps
module companion_model (
    // Clock and reset
    input  wire logic ref_clk,
    input  wire logic rst,
    // Bench controls
    input  wire logic tickOn,
    input  wire logic restartOn,
    input  wire logic eventReq,
    // Toward the timer
    output logic      companionTick,
    output logic      companionRestart,
    output logic      eventIn
);
    logic [2:0] phaseReg; // Companion prescaler phase

    ////////////////////////////////////////////////////////////////////////
    // Prescaler runs always, so the tick spacing never depends on controls
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            phaseReg <= 3'h0;
        end else begin
            phaseReg <= phaseReg + 3'h1;
        end
    end

    // One tick every fourth cycle while the companion counts
    assign companionTick    = tickOn && (phaseReg[1:0] == 2'h3);
    // Overflow every second tick, so a follower never passes one
    assign companionRestart = restartOn && (phaseReg == 3'h7);
    // Event channel passes edges unfiltered and unsynchronised
    assign eventIn          = eventReq;
endmodule : companion_model

// file: dv/tb_capture_timer_control_irq.sv
// Self-checking bench for the timer control block.
// Assumes the companion model on the far side and a 125 MHz ref_clk.
`timescale 1ns/10ps
module tb_capture_timer_control_irq
    import capture_timer_pkg::*;
;
    logic       ref_clk = 1'b0;        // Bench clock
    logic       rst = 1'b1;            // Synchronous reset
    logic [3:0] regAddr = 4'h0;        // Register port
    logic [7:0] regWdata = 8'h00;
    logic       regWr = 1'b0;
    logic       regRd = 1'b0;
    logic [7:0] regRdata;
    logic       sleepStandby = 1'b0;   // Power manager
    logic       sleepPowerDown = 1'b0;
    logic       companionTick;         // From partner
    logic       companionRestart;
    logic       eventIn;
    logic       portOutValue = 1'b0;   // Port register value
    logic       pinOut;
    logic       irq;
    logic       snapshotEvent;
    logic       tickOn = 1'b0;         // Partner controls
    logic       restartOn = 1'b0;
    logic       eventReq = 1'b0;
    logic [7:0] rdVal;                 // Last byte read
    int         errors = 0;
    int         comparisons = 0;

    // Rows: address, byte written, byte read back
    logic [19:0] maskRows [10] = '{{OFF_CONTROL_A, 8'hff, 8'h57}, {OFF_CONTROL_B, 8'hff, 8'h77},
        {OFF_EVENT_CTRL, 8'hff, 8'h51}, {OFF_IRQ_ENABLE, 8'hff, 8'h01}, {OFF_IRQ_FLAGS, 8'hff, 8'h00},
        {OFF_RUN_STATE, 8'hff, 8'h00}, {OFF_DEBUG_CTRL, 8'hff, 8'h01}, {OFF_BYTE_BUFFER, 8'ha5, 8'ha5},
        {4'h2, 8'hff, 8'h00}, {4'he, 8'hff, 8'h00}};
    // Rows: control A, standby, power-down, ticks, restarts, flag expected
    logic [12:0] phaseRows [10] = '{{8'h01, 5'b00001}, {8'h03, 5'b00001}, {8'h05, 5'b00000},
        {8'h07, 5'b00000}, {8'h07, 5'b00101}, {8'h17, 5'b00110}, {8'h01, 5'b10000},
        {8'h41, 5'b10001}, {8'h47, 5'b10100}, {8'h41, 5'b01000}};

    always #4 ref_clk = ~ref_clk;

    capture_timer_control_irq u_dut (.ref_clk(ref_clk), .rst(rst), .regAddr(regAddr), .regWdata(regWdata),
        .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .sleepStandby(sleepStandby),
        .sleepPowerDown(sleepPowerDown), .companionTick(companionTick), .companionRestart(companionRestart),
        .eventIn(eventIn), .portOutValue(portOutValue), .pinOut(pinOut), .irq(irq),
        .snapshotEvent(snapshotEvent));
    companion_model u_partner (.ref_clk(ref_clk), .rst(rst), .tickOn(tickOn), .restartOn(restartOn),
        .eventReq(eventReq), .companionTick(companionTick), .companionRestart(companionRestart),
        .eventIn(eventIn));

    ////////////////////////////////////////////////////////////////////////
    // Compare and count; four-state equality so unknowns never match
    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    // One-cycle write strobe
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        regAddr  <= a;
        regWdata <= d;
        regWr    <= 1'b1;
        @(posedge ref_clk);
        regWr    <= 1'b0;
    endtask : wr

    // One-cycle read; data stands only in the following cycle
    task automatic rd(input logic [3:0] a);
        @(posedge ref_clk);
        regAddr <= a;
        regRd   <= 1'b1;
        @(posedge ref_clk);
        regRd   <= 1'b0;
        #1 rdVal = regRdata;
    endtask : rd

    // Run the counter from zero for 60 cycles, then check the flag
    task automatic phase(input logic [12:0] row);
        wr(OFF_CONTROL_A, 8'h00);
        wr(OFF_COUNTER_LO, 8'h00);
        wr(OFF_COUNTER_HI, 8'h00);
        wr(OFF_IRQ_FLAGS, 8'h01);
        sleepStandby   <= row[4];
        sleepPowerDown <= row[3];
        tickOn         <= row[2];
        restartOn      <= row[1];
        wr(OFF_CONTROL_A, row[12:5]);
        repeat (60) @(posedge ref_clk);
        wr(OFF_CONTROL_A, 8'h00);
        sleepStandby   <= 1'b0;
        sleepPowerDown <= 1'b0;
        rd(OFF_IRQ_FLAGS);
        chk("phase flag", rdVal, {7'h00, row[0]});
    endtask : phase

    // Set control B and port value, then look at the pin
    task automatic pin(input logic [7:0] c, input logic p, input logic e);
        wr(OFF_CONTROL_B, c);
        portOutValue <= p;
        repeat (3) @(posedge ref_clk);
        #1 chk("pin level", {7'h00, pinOut}, {7'h00, e});
    endtask : pin

    task automatic close_out();
        $display("counts: %0d comparisons, %0d mismatches", comparisons, errors);
        if (errors == 0 && comparisons > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : close_out

    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        repeat (6) @(posedge ref_clk);
        rst <= 1'b0;
        for (int i = 0; i < 16; i++) begin
            rd(4'(i));
            chk("reset value", rdVal, 8'h00);
        end
        chk("reset irq", {7'h00, irq}, 8'h00);
        $display("test reset done");
        foreach (maskRows[i]) begin
            wr(maskRows[i][19:16], maskRows[i][15:8]);
            rd(maskRows[i][19:16]);
            chk("mask readback", rdVal, maskRows[i][7:0]);
            wr(maskRows[i][19:16], 8'h00);
        end
        for (int m = 0; m < 8; m++) begin
            wr(OFF_CONTROL_B, 8'(m));
            rd(OFF_CONTROL_B);
            chk("mode code", rdVal, 8'(m));
        end
        wr(OFF_CONTROL_B, 8'h00);
        $display("test registers done");
        // Top of five; each row must count there or be held off it
        wr(OFF_COMPARE_LO, 8'h05);
        wr(OFF_COMPARE_HI, 8'h00);
        foreach (phaseRows[i]) begin
            phase(phaseRows[i]);
        end
        $display("test clocking and sleep done");
        phase(phaseRows[0]);
        chk("masked irq", {7'h00, irq}, 8'h00);
        wr(OFF_IRQ_ENABLE, 8'h01);
        #1 chk("enabled irq", {7'h00, irq}, 8'h01);
        wr(OFF_IRQ_FLAGS, 8'h00);
        #1 chk("irq after zero write", {7'h00, irq}, 8'h01);
        wr(OFF_IRQ_FLAGS, 8'h01);
        #1 chk("irq after clear", {7'h00, irq}, 8'h00);
        $display("test interrupt done");
        pin(8'h00, 1'b1, 1'b1);
        pin(8'h30, 1'b0, 1'b1);
        pin(8'h10, 1'b1, 1'b0);
        pin(8'h76, 1'b0, 1'b0);
        // Asynchronous one-shot: output must rise before any sync stage
        wr(OFF_EVENT_CTRL, 8'h01);
        wr(OFF_CONTROL_A, 8'h01);
        eventReq <= 1'b1;
        #1 chk("async start", {7'h00, pinOut}, 8'h01);
        $display("test pin done");
        wr(OFF_CONTROL_A, 8'h00);
        eventReq <= 1'b0;
        wr(OFF_CONTROL_B, 8'h02);
        wr(OFF_IRQ_FLAGS, 8'h01);
        wr(OFF_CONTROL_A, 8'h01);
        eventReq <= 1'b1;
        repeat (8) @(posedge ref_clk);
        rd(OFF_IRQ_FLAGS);
        chk("capture flag", rdVal, 8'h01);
        chk("capture irq", {7'h00, irq}, 8'h01);
        rd(OFF_COMPARE_LO);
        rd(OFF_IRQ_FLAGS);
        chk("capture read clear", rdVal, 8'h00);
        $display("test capture done");
        wr(OFF_CONTROL_A, 8'h00);
        wr(OFF_COMPARE_LO, 8'h34);
        wr(OFF_COMPARE_HI, 8'h12);
        rd(OFF_COMPARE_LO);
        chk("word low", rdVal, 8'h34);
        rd(OFF_BYTE_BUFFER);
        chk("buffer high", rdVal, 8'h12);
        rd(OFF_COMPARE_HI);
        chk("word high", rdVal, 8'h12);
        $display("test word access done");
        close_out();
    end

    // Watchdog: the sequence needs far less than this span
    initial begin
        #100000;
        errors++;
        close_out();
    end
endmodule : tb_capture_timer_control_irq

// file: inc/capture_timer_pkg.sv
// Package for the capture timer control block: register map, fields, modes.
// Assumes a byte-wide register port on ref_clk and a single clock domain.
package capture_timer_pkg;

    // Register offsets (byte addresses)
    localparam logic [3:0] OFF_CONTROL_A   = 4'h0;
    localparam logic [3:0] OFF_CONTROL_B   = 4'h1;
    localparam logic [3:0] OFF_EVENT_CTRL  = 4'h4;
    localparam logic [3:0] OFF_IRQ_ENABLE  = 4'h5;
    localparam logic [3:0] OFF_IRQ_FLAGS   = 4'h6;
    localparam logic [3:0] OFF_RUN_STATE   = 4'h7;
    localparam logic [3:0] OFF_DEBUG_CTRL  = 4'h8;
    localparam logic [3:0] OFF_BYTE_BUFFER = 4'h9;
    localparam logic [3:0] OFF_COUNTER_LO  = 4'ha;
    localparam logic [3:0] OFF_COUNTER_HI  = 4'hb;
    localparam logic [3:0] OFF_COMPARE_LO  = 4'hc;
    localparam logic [3:0] OFF_COMPARE_HI  = 4'hd;

    // Field positions
    localparam int BIT_ENABLE       = 0;
    localparam int BIT_CLOCK_SOURCE_SELECT_LO    = 1;
    localparam int BIT_SYNC_COMP    = 4;
    localparam int BIT_RUN_STANDBY  = 6;
    localparam int BIT_WAVE_EN      = 4;
    localparam int BIT_INIT_LEVEL   = 5;
    localparam int BIT_ASYNC_START  = 6;
    localparam int BIT_EVENT_EN     = 0;
    localparam int BIT_EVENT_EDGE   = 4;
    localparam int BIT_SNAPSHOT     = 0;

    // Write masks of implemented bits
    localparam logic [7:0] MASK_CONTROL_A  = 8'h57;
    localparam logic [7:0] MASK_CONTROL_B  = 8'h77;
    localparam logic [7:0] MASK_EVENT_CTRL = 8'h51;
    localparam logic [7:0] MASK_ONE_BIT    = 8'h01;
    localparam logic [7:0] RESET_BYTE      = 8'h00;
    localparam logic [15:0] RESET_WORD     = 16'h0000;
    localparam logic [15:0] COUNT_BOTTOM   = 16'h0000;
    localparam logic [15:0] COUNT_STEP     = 16'h0001;

    // Clock source select codes
    typedef enum logic [1:0] {
        FULL_RATE_CLOCK      = 2'h0,
        HALF_RATE_CLOCK      = 2'h1,
        COMPANION_TIMER_CLOCK = 2'h3
    } clock_source_t;
    localparam logic [1:0] CLOCK_SOURCE_SELECT_RESERVED = 2'h2;

    // Timer mode codes
    typedef enum logic [2:0] {
        PERIODIC_MODE             = 3'h0,
        TIMEOUT_MODE              = 3'h1,
        CAPTURE_MODE              = 3'h2,
        PERIOD_MEASURE_MODE       = 3'h3,
        HIGH_TIME_MODE            = 3'h4,
        PERIOD_AND_HIGH_TIME_MODE = 3'h5,
        ONE_SHOT_MODE             = 3'h6,
        EIGHT_BIT_PULSE_MODE      = 3'h7
    } timer_mode_field_t;

    // Sleep state from the power manager
    typedef struct packed {
        logic standby;
        logic powerDown;
    } sleep_t;

    // Register bus request
    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } bus_req_t;

    // Capture modes allow clear-on-read of the snapshot flag
    function automatic logic is_capture_mode(input logic [2:0] m);
        return (m >= CAPTURE_MODE) && (m <= PERIOD_AND_HIGH_TIME_MODE);
    endfunction : is_capture_mode

endpackage : capture_timer_pkg
